// ==== pkg/lacc_pkg.sv ====
package lacc_pkg;
    // configuration word layout
    localparam int          CFG_W        = 20;
    localparam int          PFX_LSB      = 17;
    localparam logic [2:0]  PFX_ADAPT    = 3'h5;
    localparam logic [2:0]  PFX_LOAD     = 3'h6;
    localparam int          MIN_SEL_BIT  = 15;
    localparam int          DEC_LSB      = 13;
    localparam int          UP_OFF_LSB   = 8;
    localparam int          INC_LSB      = 5;
    localparam int          LOW_TH_LSB   = 0;
    localparam int          FILT_BIT     = 16;
    localparam int          SENS_LSB     = 8;
    localparam int          CS_LSB       = 0;
    localparam int          TH_SHIFT     = 5;
    localparam int          SENS_SHIFT   = 4;
    localparam int          FILT_LAST    = 3;
    // register map
    localparam logic [7:0]  OFS_CFG      = 8'h00;
    localparam logic [7:0]  OFS_STATE    = 8'h04;
    localparam logic [7:0]  OFS_IRQ      = 8'h08;
    localparam logic [7:0]  OFS_MASK     = 8'h0c;
    localparam int          ST_LOAD_LSB  = 0;
    localparam int          ST_CUR_LSB   = 16;
    localparam int          ST_STALL_BIT = 24;
    localparam int          IRQ_STALL    = 0;
    localparam int          IRQ_UP       = 1;
    localparam int          IRQ_DOWN     = 2;
    localparam int          IRQ_W        = 3;
    // reset values
    localparam logic [12:0] ADAPT_RST    = 13'h0;
    localparam logic [12:0] LOAD_RST     = 13'h0;
    localparam logic [2:0]  MASK_RST     = 3'h0;

    typedef struct packed {
        logic       min_sel;
        logic [1:0] dec;
        logic [3:0] up_off;
        logic [1:0] inc;
        logic [3:0] low_th;
    } adapt_cfg_t;

    typedef struct packed {
        logic              filt;
        logic signed [6:0] sens;
        logic [4:0]        cs;
    } load_cfg_t;

    typedef struct packed {
        adapt_cfg_t       a;
        load_cfg_t        l;
        logic [4:0]       cur;
        logic [5:0]       dcnt;
        logic [1:0]       fcnt;
        logic [11:0]      facc;
        logic [9:0]       load;
        logic             lv;
        logic             stall;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic             irq_o;
        logic [31:0]      rdata;
    } state_t;

    function automatic logic [5:0] dec_target(input logic [1:0] code);
        case (code)
            2'h0:    dec_target = 6'h20;
            2'h1:    dec_target = 6'h08;
            2'h2:    dec_target = 6'h02;
            default: dec_target = 6'h01;
        endcase
    endfunction : dec_target
endpackage : lacc_pkg

// ==== hdl/coil_scale.sv ====
`timescale 1ns/1ps
module coil_scale #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] i_cur,
    input  wire logic [4:0]   i_scale,
    output logic [W-1:0]      o_cur
);
    logic [W+5:0] prod;

    // scale is biased by one: 0 gives 1/32, 31 gives full
    always_comb begin
        prod = {6'h0, i_cur} * {{W{1'b0}}, 1'b0, i_scale + 5'h0} + {6'h0, i_cur};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cur <= '0;
        end else begin
            o_cur <= prod[W+4:5];
        end
    end

    a_coil_scaled: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> o_cur == $past(prod[W+4:5]) && ($past(i_scale) != 5'h1f || o_cur == $past(i_cur))
            && ($past(i_scale) != 5'h0 || o_cur == ($past(i_cur) >> 5)))
        else $error("coil scaling wrong");
endmodule : coil_scale

// ==== hdl/load_adaptive_current.sv ====
`timescale 1ns/1ps
// Behaviour
// - prefix 101 loads adaptive current word
// - prefix 110 loads threshold and scale word
// - floor is half or quarter scale
// - decrement after 32/8/2/1 high samples
// - upper threshold is (low+offset+1)*32
// - low sample raises current 1/2/4/8
// - zero lower threshold disables adaptation
// - raise when load below low*32
// - filter updates load every four fullsteps
// - sensitivity threshold is signed seven bits
// - sensitivity shifts readout and stall flag
// - coil currents scaled by (cur+1)/32
// - scale applies in every drive mode
module load_adaptive_current #(
    parameter int COIL_W = 8
) (
    // clock and reset
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_RESETN,
    // register bus
    input  wire logic [7:0]        I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic [31:0]            O_RDATA,
    // load measurement, one strobe per fullstep
    input  wire logic              I_LOAD_STROBE,
    input  wire logic [9:0]        I_LOAD_RAW,
    // digital coil currents
    input  wire logic [COIL_W-1:0] I_COIL_A,
    input  wire logic [COIL_W-1:0] I_COIL_B,
    output logic [COIL_W-1:0]      O_COIL_A,
    output logic [COIL_W-1:0]      O_COIL_B,
    // status
    output logic [9:0]             O_LOAD_VALUE,
    output logic [4:0]             O_CUR_SCALE,
    output logic                   O_STALL_INDICATOR_OUT,
    output logic                   O_IRQ
);
    localparam int IRQ_WL = lacc_pkg::IRQ_W - 1;

    lacc_pkg::state_t st;
    lacc_pkg::state_t n;

    logic       cfg_wr;
    logic [2:0] pfx;
    logic [4:0] floor_v;
    logic [9:0] lower_v;
    logic [9:0] upper_v;
    logic [5:0] up_sum;
    logic [4:0] up_tgt;
    logic       adapt_en;

    assign cfg_wr = I_WR && (I_ADDR == lacc_pkg::OFS_CFG);
    assign pfx    = I_WDATA[lacc_pkg::PFX_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // thresholds and limits from the current settings

    always_comb begin
        adapt_en = (st.a.low_th != 4'h0);
        if (st.a.min_sel) begin
            floor_v = st.l.cs >> 2;
        end else begin
            floor_v = st.l.cs >> 1;
        end
        lower_v = {1'b0, st.a.low_th, 5'h0};
        upper_v = {5'({1'b0, st.a.low_th} + {1'b0, st.a.up_off} + 5'h1), 5'h0};
        up_sum  = {1'b0, st.cur} + (6'h1 << st.a.inc);
        if (up_sum > {1'b0, st.l.cs}) begin
            up_tgt = st.l.cs;
        end else begin
            up_tgt = up_sum[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [5:0]         tgt;
        logic [11:0]        avg;
        logic [9:0]         raw;
        logic signed [12:0] adj;
        logic [4:0]         nfloor;
        logic [IRQ_WL:0]    set;
        logic [IRQ_WL:0]    clr;
        tgt    = '0;
        avg    = '0;
        raw    = '0;
        adj    = '0;
        nfloor = '0;
        set    = '0;
        clr    = '0;
        n      = st;
        n.lv   = 1'b0;
        n.rdata = '0;

        // configuration words; other prefixes belong elsewhere
        if (cfg_wr && pfx == lacc_pkg::PFX_ADAPT) begin
            n.a.min_sel = I_WDATA[lacc_pkg::MIN_SEL_BIT];
            n.a.dec     = I_WDATA[lacc_pkg::DEC_LSB +: 2];
            n.a.up_off  = I_WDATA[lacc_pkg::UP_OFF_LSB +: 4];
            n.a.inc     = I_WDATA[lacc_pkg::INC_LSB +: 2];
            n.a.low_th  = I_WDATA[lacc_pkg::LOW_TH_LSB +: 4];
            n.dcnt      = '0;
        end
        // reserved bits are not stored, so stray ones do no harm
        if (cfg_wr && pfx == lacc_pkg::PFX_LOAD) begin
            n.l.filt = I_WDATA[lacc_pkg::FILT_BIT];
            n.l.sens = I_WDATA[lacc_pkg::SENS_LSB +: 7];
            n.l.cs   = I_WDATA[lacc_pkg::CS_LSB +: 5];
            n.fcnt   = '0;
            n.facc   = '0;
        end

        // load sampling, optionally averaged over four fullsteps
        if (I_LOAD_STROBE) begin
            if (st.l.filt) begin
                avg    = st.facc + {2'h0, I_LOAD_RAW};
                n.facc = avg;
                n.fcnt = st.fcnt + 2'h1;
                if (st.fcnt == 2'(lacc_pkg::FILT_LAST)) begin
                    raw    = avg[11:2];
                    n.lv   = 1'b1;
                    n.facc = '0;
                end
            end else begin
                raw  = I_LOAD_RAW;
                n.lv = 1'b1;
            end
        end
        if (n.lv) begin
            // signed offset moves readout range and stall point together
            adj = $signed({3'h0, raw}) + ($signed({{6{st.l.sens[6]}}, st.l.sens}) <<< lacc_pkg::SENS_SHIFT);
            if (adj < 13'sd0) begin
                n.load = '0;
            end else if (adj > 13'sd1023) begin
                n.load = 10'h3ff;
            end else begin
                n.load = adj[9:0];
            end
            n.stall = (n.load == 10'h0);
        end

        // adaptive current on each fresh load value
        if (st.lv && adapt_en) begin
            if (st.load < lower_v) begin
                n.cur  = up_tgt;
                n.dcnt = '0;
                set[lacc_pkg::IRQ_UP] = (up_tgt != st.cur);
            end else if (st.load >= upper_v) begin
                tgt    = lacc_pkg::dec_target(st.a.dec);
                n.dcnt = st.dcnt + 6'h1;
                if (st.dcnt + 6'h1 >= tgt) begin
                    n.dcnt = '0;
                    if (st.cur > floor_v) begin
                        n.cur = st.cur - 5'h1;
                        set[lacc_pkg::IRQ_DOWN] = 1'b1;
                    end
                end
            end else begin
                n.dcnt = '0;
            end
        end

        // limits follow any new setting in the same cycle
        if (n.a.min_sel) begin
            nfloor = n.l.cs >> 2;
        end else begin
            nfloor = n.l.cs >> 1;
        end
        if (n.a.low_th == 4'h0) begin
            n.cur = n.l.cs;
        end else if (n.cur > n.l.cs) begin
            n.cur = n.l.cs;
        end else if (n.cur < nfloor) begin
            n.cur = nfloor;
        end

        // interrupts: an event wins over a clear in the same cycle
        set[lacc_pkg::IRQ_STALL] = n.stall && !st.stall;
        if (I_WR && I_ADDR == lacc_pkg::OFS_IRQ) begin
            clr = I_WDATA[IRQ_WL:0];
        end
        if (I_WR && I_ADDR == lacc_pkg::OFS_MASK) begin
            n.mask = I_WDATA[IRQ_WL:0];
        end
        n.irq   = (st.irq & ~clr) | set;
        n.irq_o = |(n.irq & n.mask);

        // register reads, data valid the following cycle only
        if (I_RD) begin
            case (I_ADDR)
                lacc_pkg::OFS_STATE: begin
                    n.rdata[lacc_pkg::ST_LOAD_LSB +: 10] = st.load;
                    n.rdata[lacc_pkg::ST_CUR_LSB +: 5]   = st.cur;
                    n.rdata[lacc_pkg::ST_STALL_BIT]      = st.stall;
                end
                lacc_pkg::OFS_IRQ: begin
                    n.rdata[IRQ_WL:0] = st.irq;
                end
                lacc_pkg::OFS_MASK: begin
                    n.rdata[IRQ_WL:0] = st.mask;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st      <= '0;
            st.a    <= lacc_pkg::ADAPT_RST;
            st.l    <= lacc_pkg::LOAD_RST;
            st.mask <= lacc_pkg::MASK_RST;
        end else begin
            st <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign O_RDATA               = st.rdata;
    assign O_LOAD_VALUE          = st.load;
    assign O_CUR_SCALE           = st.cur;
    assign O_STALL_INDICATOR_OUT = st.stall;
    assign O_IRQ                 = st.irq_o;

    // same scaler in serial and step/direction operation
    coil_scale #(.W(COIL_W)) u_scale_a (
        .clk     (I_CLK_SYS),
        .rst_n   (I_RESETN),
        .i_cur   (I_COIL_A),
        .i_scale (st.cur),
        .o_cur   (O_COIL_A)
    );

    coil_scale #(.W(COIL_W)) u_scale_b (
        .clk     (I_CLK_SYS),
        .rst_n   (I_RESETN),
        .i_cur   (I_COIL_B),
        .i_scale (st.cur),
        .o_cur   (O_COIL_B)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_quiet_cfg;
        !cfg_wr;
    endsequence

    sequence s_high_hit;
        st.lv && adapt_en && st.load >= upper_v && st.a.dec == 2'h3 && st.cur > floor_v;
    endsequence

    sequence s_fresh_sample;
        st.lv && adapt_en;
    endsequence

    sequence s_raw_sample;
        I_LOAD_STROBE && !st.l.filt;
    endsequence

    a_route_adapt: assert property (
        cfg_wr && pfx == lacc_pkg::PFX_ADAPT |=> st.a.low_th == $past(I_WDATA[3:0])
            && st.a.up_off == $past(I_WDATA[11:8]) && st.a.min_sel == $past(I_WDATA[15]))
        else $error("adaptive word not taken");

    a_route_load: assert property (
        cfg_wr && pfx == lacc_pkg::PFX_LOAD |=> st.l.cs == $past(I_WDATA[4:0])
            && st.l.filt == $past(I_WDATA[16]))
        else $error("threshold word not taken");

    a_cur_bounds: assert property (
        adapt_en |-> st.cur <= st.l.cs && st.cur >= floor_v)
        else $error("current outside limits");

    a_disable_full: assert property (
        !adapt_en |-> st.cur == st.l.cs)
        else $error("disabled but current not full");

    a_inc_step: assert property (
        st.lv && adapt_en && st.load < lower_v ##0 s_quiet_cfg |=> st.cur == $past(up_tgt))
        else $error("increment step wrong");

    a_dec_count: assert property (
        s_high_hit ##0 s_quiet_cfg |=> st.cur == $past(st.cur) - 5'h1)
        else $error("decrement missing");

    a_filter_rate: assert property (
        I_LOAD_STROBE && st.l.filt && st.fcnt != 2'h3 |=> !st.lv)
        else $error("filtered load updated early");

    a_stall_flag: assert property (
        st.lv |-> st.stall == (st.load == 10'h0))
        else $error("stall flag mismatch");

    a_rd_once: assert property (
        !I_RD |=> st.rdata == 32'h0)
        else $error("read data outside its cycle");

    a_mid_hold: assert property (
        s_fresh_sample ##0 s_quiet_cfg ##0 st.load >= 10'({6'h0, st.a.low_th} << 5)
            && st.load < 10'(({6'h0, st.a.low_th} + {6'h0, st.a.up_off} + 10'h1) << 5) |=> $stable(st.cur))
        else $error("current moved between thresholds");

    a_floor_hold: assert property (
        s_fresh_sample ##0 s_quiet_cfg ##0 st.load >= upper_v
            && st.cur <= (st.a.min_sel ? (st.l.cs >> 2) : (st.l.cs >> 1)) |=> $stable(st.cur))
        else $error("current lowered below floor");

    a_dec_wait: assert property (
        s_fresh_sample ##0 s_quiet_cfg ##0 st.load >= upper_v
            && st.dcnt + 6'h1 < lacc_pkg::dec_target(st.a.dec) |=> $stable(st.cur))
        else $error("current lowered before count");

    a_ceiling_sens: assert property (
        s_raw_sample ##0 st.l.sens == 7'h3f && I_LOAD_RAW >= 10'h010 |=> st.load == 10'h3ff)
        else $error("load not saturated high");

    a_floor_sens: assert property (
        s_raw_sample ##0 st.l.sens == 7'h40 |=> st.load == 10'h0 && st.stall)
        else $error("load not saturated low");

    a_stall_set: assert property (
        n.stall && !st.stall |=> st.irq[lacc_pkg::IRQ_STALL])
        else $error("stall event not flagged");

    a_irq_clear: assert property (
        I_WR && I_ADDR == lacc_pkg::OFS_IRQ && I_WDATA[lacc_pkg::IRQ_STALL] && !(n.stall && !st.stall)
            |=> !st.irq[lacc_pkg::IRQ_STALL])
        else $error("status bit not cleared");

    a_irq_sticky: assert property (
        st.irq[lacc_pkg::IRQ_UP] && !(I_WR && I_ADDR == lacc_pkg::OFS_IRQ) |=> st.irq[lacc_pkg::IRQ_UP])
        else $error("status bit lost");

    a_irq_level: assert property (
        (st.irq & st.mask) != '0 && !I_WR |=> O_IRQ)
        else $error("unmasked status without interrupt");
endmodule : load_adaptive_current

// ==== dv/host_ctrl_model.sv ====
`timescale 1ns/1ps
// host controller: masters the register bus and writes whole configuration words
module host_ctrl_model (
    // clock
    input  wire logic        i_clk,
    // register bus
    output logic [7:0]       o_addr,
    output logic [31:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    input  wire logic [31:0] i_rdata
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 32'h0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d; // stale data must not be mistaken for a write
    endtask : wr
    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    // reserved positions always sent as zero
    task automatic adapt(input logic m, input logic [1:0] dn, input logic [3:0] off,
                         input logic [1:0] up, input logic [3:0] lo);
        wr(8'h00, {12'h0, 3'h5, 1'b0, m, dn, 1'b0, off, 1'b0, up, 1'b0, lo});
    endtask : adapt
    task automatic load(input logic f, input logic [6:0] s, input logic [4:0] cs);
        wr(8'h00, {12'h0, 3'h6, f, 1'b0, s, 3'h0, cs});
    endtask : load
endmodule : host_ctrl_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic        I_CLK_SYS      = 1'b0;
    logic        I_RESETN       = 1'b0;
    logic        I_LOAD_STROBE  = 1'b0;
    logic [9:0]  I_LOAD_RAW     = 10'h0;
    logic [7:0]  I_COIL_A       = 8'h0;
    logic [7:0]  I_COIL_B       = 8'h0;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  coil_a;
    logic [7:0]  coil_b;
    logic [9:0]  load_value;
    logic [4:0]  cur_scale;
    logic        stall;
    logic        irq;
    int          miscompares    = 0;
    int          compares       = 0;
    int          exp_cur;
    logic [31:0] d;
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
    end
    host_ctrl_model host (.i_clk(I_CLK_SYS), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
                          .i_rdata(rdata));
    load_adaptive_current #(.COIL_W(8)) dut (
        .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_LOAD_STROBE(I_LOAD_STROBE), .I_LOAD_RAW(I_LOAD_RAW),
        .I_COIL_A(I_COIL_A), .I_COIL_B(I_COIL_B), .O_COIL_A(coil_a), .O_COIL_B(coil_b),
        .O_LOAD_VALUE(load_value), .O_CUR_SCALE(cur_scale), .O_STALL_INDICATOR_OUT(stall),
        .O_IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // one fullstep sample, then time for load, current and interrupt to settle
    task automatic strobe(input logic [9:0] raw);
        @(posedge I_CLK_SYS);
        I_LOAD_STROBE <= 1'b1;
        I_LOAD_RAW    <= raw;
        @(posedge I_CLK_SYS);
        I_LOAD_STROBE <= 1'b0;
        I_LOAD_RAW    <= ~raw;
        repeat (4) @(posedge I_CLK_SYS);
        #1;
    endtask : strobe
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_map;
        chk(cur_scale, 32'h0, "scale after reset");
        host.rd(8'h04, d);
        chk(d, 32'h0, "state after reset");
        host.rd(8'h00, d);
        chk(d, 32'h0, "config word reads zero");
        host.rd(8'h10, d);
        chk(d, 32'h0, "unmapped read");
    endtask : t_reset_map
    task automatic t_scale;
        host.load(1'b0, 7'h00, 5'h14);
        I_COIL_A <= 8'hc8;
        I_COIL_B <= 8'h1f;
        repeat (3) @(posedge I_CLK_SYS);
        #1;
        chk(cur_scale, 32'h14, "disabled adaptation keeps full scale");
        chk(coil_a, (200 * 21) >> 5, "coil a scaled");
        chk(coil_b, (31 * 21) >> 5, "coil b scaled");
        host.wr(8'h00, 32'h000e_0000);
        repeat (3) @(posedge I_CLK_SYS);
        #1;
        chk(cur_scale, 32'h14, "foreign prefix ignored");
    endtask : t_scale
    task automatic t_floor_and_step;
        host.load(1'b0, 7'h00, 5'h1f);
        host.adapt(1'b0, 2'h3, 4'h2, 2'h0, 4'h1);
        repeat (20) strobe(10'd128);
        chk(cur_scale, 32'd15, "half floor");
        strobe(10'd127);
        chk(cur_scale, 32'd15, "just below upper threshold");
        host.adapt(1'b1, 2'h3, 4'h2, 2'h0, 4'h1);
        repeat (10) strobe(10'd128);
        chk(cur_scale, 32'd7, "quarter floor");
        strobe(10'd32);
        chk(cur_scale, 32'd7, "at lower threshold no raise");
        exp_cur = 7;
        for (int i = 0; i < 6; i++) begin
            host.adapt(1'b1, 2'h3, 4'h2, 2'(i > 3 ? 3 : i), 4'h1);
            strobe(10'd31);
            exp_cur = exp_cur + (1 << (i > 3 ? 3 : i));
            if (exp_cur > 31) exp_cur = 31;
            chk(cur_scale, exp_cur, "raise step");
        end
    endtask : t_floor_and_step
    task automatic t_decrement;
        int n;
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 32 : (c == 1) ? 8 : (c == 2) ? 2 : 1;
            host.adapt(1'b1, 2'(c), 4'h2, 2'h0, 4'h1);
            repeat (n - 1) strobe(10'd128);
            chk(cur_scale, exp_cur, "no decrement before count");
            strobe(10'd128);
            exp_cur--;
            chk(cur_scale, exp_cur, "decrement at count");
        end
        host.rd(8'h04, d);
        chk(d, (exp_cur << 16) | 128, "state word");
    endtask : t_decrement
    task automatic t_sensitivity;
        host.load(1'b0, 7'h7f, 5'h1f);
        strobe(10'd100);
        chk(load_value, 32'd84, "negative threshold");
        host.load(1'b0, 7'h3f, 5'h1f);
        strobe(10'd100);
        chk(load_value, 32'd1023, "positive saturation");
        host.load(1'b0, 7'h40, 5'h1f);
        strobe(10'd500);
        chk(load_value, 32'd0, "most negative threshold");
        chk(stall, 32'h1, "stall indicator");
    endtask : t_sensitivity
    task automatic t_irq;
        chk(irq, 32'h0, "masked interrupt");
        host.rd(8'h08, d);
        chk(d[0], 32'h1, "stall status set");
        host.wr(8'h0c, 32'h1);
        repeat (2) @(posedge I_CLK_SYS);
        #1;
        chk(irq, 32'h1, "unmasked interrupt");
        host.wr(8'h08, 32'h1);
        repeat (2) @(posedge I_CLK_SYS);
        #1;
        chk(irq, 32'h0, "cleared interrupt");
        host.rd(8'h08, d);
        chk(d[0], 32'h0, "stall status cleared");
    endtask : t_irq
    task automatic t_filter;
        host.load(1'b1, 7'h00, 5'h1f);
        strobe(10'd100);
        strobe(10'd200);
        strobe(10'd300);
        chk(load_value, 32'd0, "filtered load held");
        strobe(10'd400);
        chk(load_value, 32'd250, "filtered average");
    endtask : t_filter
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge I_CLK_SYS);
        miscompares++;
        $display("[ERR] %0t run took too long", $time);
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge I_CLK_SYS);
        I_RESETN <= 1'b1;
        @(posedge I_CLK_SYS);
        #1;
        t_reset_map;
        t_scale;
        t_floor_and_step;
        t_decrement;
        t_sensitivity;
        t_irq;
        t_filter;
        report_and_stop;
    end
endmodule : tb
